/* File: src/usc_pkg.sv */
// Package for the serial status and control register block.
// Assumes a byte-wide register port and a fixed-rate bit clock count.
package usc_pkg;
  // Register addresses
  localparam logic [7:0] USC_ADDR_STATUS = 8'h50;
  localparam logic [7:0] USC_ADDR_DATA = 8'h51;
  localparam logic [7:0] USC_ADDR_CTRL1 = 8'h53;
  localparam logic [7:0] USC_ADDR_CTRL2 = 8'h54;
  // Reset values
  localparam logic [7:0] USC_STATUS_RESET = 8'hC0;
  localparam logic [7:0] USC_CTRL1_RESET = 8'h00;
  localparam logic [7:0] USC_CTRL2_RESET = 8'h00;
  // Control one field positions
  localparam int USC_C1_RX9 = 7;
  localparam int USC_C1_TX9 = 6;
  localparam int USC_C1_LPS = 5;
  localparam int USC_C1_M = 4;
  localparam int USC_C1_WAKE = 3;
  localparam int USC_C1_PCE = 2;
  localparam int USC_C1_PS = 1;
  localparam int USC_C1_PIE = 0;
  // Control two field positions
  localparam int USC_C2_TIE = 7;
  localparam int USC_C2_TX_DONE_IRQ_ENABLE = 6;
  localparam int USC_C2_RIE = 5;
  localparam int USC_C2_IDLE_IRQ_ENABLE = 4;
  localparam int USC_C2_TE = 3;
  localparam int USC_C2_RE = 2;
  localparam int USC_C2_MUTE = 1;
  localparam int USC_C2_SBK = 0;
  // Clock cycles per serial bit
  localparam int USC_BIT_CLKS = 16;
  // Frame lengths in bits
  localparam logic [3:0] USC_FRAME8 = 4'hA;
  localparam logic [3:0] USC_FRAME9 = 4'hB;
  // Parity of the data bits below the parity position
  function automatic logic usc_par(input logic [8:0] d, input logic nine);
    usc_par = nine ? ^d[7:0] : ^d[6:0];
  endfunction
endpackage

/* File: src/usc_rx.sv */
// Serial receiver: start search, majority sampling, noise, framing, idle.
// Assumes rx_i is an asynchronous pin; enable stops new frames and idle counting only.
`timescale 1ns/1ps
`default_nettype none
module usc_rx import usc_pkg::*; #(
  parameter int BIT_CLKS = USC_BIT_CLKS
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic rx_i,
  input wire logic enable_i,
  input wire logic nine_bit_i,
  output logic start_o,
  output logic word_valid_o,
  output logic [8:0] word_o,
  output logic noise_o,
  output logic frame_err_o,
  output logic idle_o
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usc_rx_state_t;
  localparam int HALF = BIT_CLKS / 2;
  usc_rx_state_t state;
  logic sync1, sync2;
  logic [15:0] cnt;
  logic [15:0] idle_cnt;
  logic [3:0] bits;
  logic [1:0] ones;
  logic [8:0] shreg;
  logic nine, noisy, armed;
  logic sample, mid_end, bit_end, maj, next_noise;

  // Two-stage synchroniser
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= rx_i;
      sync2 <= sync1;
    end
  end

  assign sample = (cnt >= 16'(HALF - 1)) && (cnt <= 16'(HALF + 1));
  assign mid_end = cnt == 16'(HALF + 2);
  assign bit_end = cnt == 16'(BIT_CLKS - 1);
  assign maj = ones >= 2'd2;
  assign next_noise = noisy | ((ones != 2'd0) && (ones != 2'd3));

  // Frame sequencing with three-sample majority
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= RX_IDLE;
      cnt <= 16'h0000;
      bits <= 4'h0;
      ones <= 2'd0;
      shreg <= 9'h000;
      nine <= 1'b0;
      noisy <= 1'b0;
      start_o <= 1'b0;
      word_valid_o <= 1'b0;
      word_o <= 9'h000;
      noise_o <= 1'b0;
      frame_err_o <= 1'b0;
    end else begin
      start_o <= 1'b0;
      word_valid_o <= 1'b0;
      cnt <= (state == RX_IDLE || bit_end) ? 16'h0000 : cnt + 16'h0001;
      if (sample) begin
        ones <= ones + {1'b0, sync2};
      end
      case (state)
        RX_IDLE: begin
          ones <= 2'd0;
          if (enable_i && !sync2) begin
            state <= RX_START;
            nine <= nine_bit_i;
            noisy <= 1'b0;
            bits <= 4'h0;
            start_o <= 1'b1;
          end
        end
        RX_START: begin
          if (bit_end) begin
            ones <= 2'd0;
            noisy <= next_noise;
            state <= maj ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (bit_end) begin
            ones <= 2'd0;
            noisy <= next_noise;
            shreg <= {maj, shreg[8:1]};
            bits <= bits + 4'h1;
            if (bits == (nine ? 4'h8 : 4'h7)) begin
              state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (mid_end) begin
            state <= RX_IDLE;
            word_valid_o <= 1'b1;
            word_o <= nine ? shreg : {1'b0, shreg[8:1]};
            noise_o <= next_noise;
            frame_err_o <= !maj;
          end
        end
        default: state <= RX_IDLE;
      endcase
    end
  end

  // Idle frame detection, armed by a received start bit
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      idle_cnt <= 16'h0000;
      armed <= 1'b0;
      idle_o <= 1'b0;
    end else begin
      idle_o <= 1'b0;
      if (start_o) begin
        armed <= 1'b1;
      end
      if (state != RX_IDLE || !sync2 || !enable_i) begin
        idle_cnt <= 16'h0000;
      end else if (armed) begin
        idle_cnt <= idle_cnt + 16'h0001;
        if (idle_cnt == 16'((nine_bit_i ? 11 : 10) * BIT_CLKS - 1)) begin
          idle_o <= 1'b1;
          armed <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/usc_top.sv */
// Serial transceiver status and control registers with transmitter.
// Assumes a byte register port on ref_clk_i; rx pin is asynchronous.
// What this block does
// - Buffer-empty flag sets on buffer-to-shifter move; move waits for flag clear.
// - Done flag sets after a data frame only; enable gates its interrupt.
// - Rx-ready sets on word to buffer; status then data read clears.
// - Idle flag sets on idle line; rearmed only by a new rx-ready.
// - Word arriving while rx-ready set raises overrun; buffer kept.
// - Noise flag sets with the word; no interrupt of its own.
// - Framing flag on bad stop or break; overrun alone when both.
// - Parity fail flag on bad parity; interrupts when its enable is set.
// - Status reads 8'hC0 after reset.
// - Nine-bit mode: ninth rx bit stored, ninth tx bit sent.
// - Low-power stop halts transmit and receive after the current frame.
// - Word length bit picks eight or nine data bits, one start, one stop.
// - Wake method bit picks idle-line or address-mark wake-up.
// - Parity goes in top data position and is checked; applies next frame.
// - Parity select: even when zero, odd when one; applies next frame.
// - Interrupt for each flag but noise and framing, with its enable; rx-ready and overrun ones need receiver on.
// - Transmit enable pulsed low mid-frame queues an idle preamble.
// - Transmit enable waits one bit time before the first frame.
// - Receive enable starts the search for a start bit.
// - Mute bit set and cleared by software, cleared by wake-up.
// - Break bit set then cleared sends one break after current word.
// - Muted receiver sets no rx flags and raises no rx interrupt.
// - Idle-line wake clears mute without setting idle.
// - Address-mark wake clears mute and receives the word normally.
// - All enabled events share one interrupt output.
`timescale 1ns/1ps
`default_nettype none
module usc_top import usc_pkg::*; #(
  parameter int BIT_CLKS = USC_BIT_CLKS
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic rx_i,
  output logic tx_o,
  output logic tx_oe_o,
  output logic irq_o
);
  typedef enum logic [1:0] {TX_OFF, TX_WAIT, TX_READY, TX_SHIFT} usc_tx_state_t;
  typedef enum logic [1:0] {K_DATA, K_PREAMBLE, K_BREAK} usc_kind_t;

  logic [7:0] ctrl1, ctrl2;
  logic [7:0] tx_buffer, rx_buffer;
  logic rx_ninth_bit;
  logic tx_buffer_empty_flag, tx_done_flag, rx_ready_flag, idle_flag;
  logic overrun_flag, noise_flag, framing_flag, parity_fail_flag;
  logic status_seen, idle_armed;
  logic rx_nine, rx_pce, rx_ps;
  logic rx_start, rx_valid, rx_noise, rx_ferr, rx_idle;
  logic [8:0] rx_word;
  logic tx_ninth_bit, low_power_stop, nine_bit, wake_addr_mode;
  logic parity_enable, parity_odd_select, parity_irq_enable;
  logic tx_empty_irq_enable, tx_done_irq_enable, rx_irq_enable;
  logic idle_irq_enable, tx_enable, rx_enable, rx_mute, send_break_bit;
  usc_tx_state_t tx_state;
  usc_kind_t tx_kind;
  logic [11:0] tx_shift;
  logic [3:0] tx_bits;
  logic [15:0] tx_cnt;
  logic te_prev, sbk_prev, preamble_pend, break_pend;
  logic tx_bit_end, tx_load, tx_frame_end, te_rise, sbk_fall;
  logic wr_data, rd_data, rd_status, clr_tx, clr_rx;
  logic rx_msb, wake_addr, rx_accept, rx_load, rx_perr, idle_wake;
  logic [8:0] tx_word;

  assign tx_ninth_bit = ctrl1[USC_C1_TX9];
  assign low_power_stop = ctrl1[USC_C1_LPS];
  assign nine_bit = ctrl1[USC_C1_M];
  assign wake_addr_mode = ctrl1[USC_C1_WAKE];
  assign parity_enable = ctrl1[USC_C1_PCE];
  assign parity_odd_select = ctrl1[USC_C1_PS];
  assign parity_irq_enable = ctrl1[USC_C1_PIE];
  assign tx_empty_irq_enable = ctrl2[USC_C2_TIE];
  assign tx_done_irq_enable = ctrl2[USC_C2_TX_DONE_IRQ_ENABLE];
  assign rx_irq_enable = ctrl2[USC_C2_RIE];
  assign idle_irq_enable = ctrl2[USC_C2_IDLE_IRQ_ENABLE];
  assign tx_enable = ctrl2[USC_C2_TE];
  assign rx_enable = ctrl2[USC_C2_RE];
  assign rx_mute = ctrl2[USC_C2_MUTE];
  assign send_break_bit = ctrl2[USC_C2_SBK];

  // Register port decode
  assign wr_data = wr_i && (addr_i == USC_ADDR_DATA);
  assign rd_data = rd_i && (addr_i == USC_ADDR_DATA);
  assign rd_status = rd_i && (addr_i == USC_ADDR_STATUS);
  assign clr_tx = wr_data && status_seen;
  assign clr_rx = rd_data && status_seen;

  // Receiver
  usc_rx #(
    .BIT_CLKS(BIT_CLKS)
  ) u_rx (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .rx_i(rx_i),
    .enable_i(rx_enable && !low_power_stop),
    .nine_bit_i(nine_bit),
    .start_o(rx_start),
    .word_valid_o(rx_valid),
    .word_o(rx_word),
    .noise_o(rx_noise),
    .frame_err_o(rx_ferr),
    .idle_o(rx_idle)
  );

  // Frame format settings taken at start bit
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_nine <= 1'b0;
      rx_pce <= 1'b0;
      rx_ps <= 1'b0;
    end else if (rx_start) begin
      rx_nine <= nine_bit;
      rx_pce <= parity_enable;
      rx_ps <= parity_odd_select;
    end
  end

  // Receive event qualification
  assign rx_msb = rx_nine ? rx_word[8] : rx_word[7];
  assign wake_addr = rx_valid && rx_mute && wake_addr_mode && rx_msb;
  assign rx_accept = rx_valid && (!rx_mute || wake_addr);
  assign rx_load = rx_accept && !rx_ready_flag;
  assign rx_perr = rx_pce && (((rx_nine ? ^rx_word[8:0] : ^rx_word[7:0])) != rx_ps);
  assign idle_wake = rx_idle && rx_mute && !wake_addr_mode;

  // Receive data buffer
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_buffer <= 8'h00;
      rx_ninth_bit <= 1'b0;
    end else if (rx_load) begin
      rx_buffer <= rx_word[7:0];
      if (rx_nine) begin
        rx_ninth_bit <= rx_word[8];
      end
    end
  end

  // Status read record
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_seen <= 1'b0;
    end else if (rd_status) begin
      status_seen <= 1'b1;
    end else if (wr_data || rd_data) begin
      status_seen <= 1'b0;
    end
  end

  // Status flags, a set beats a clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      {tx_buffer_empty_flag, tx_done_flag, rx_ready_flag, idle_flag,
       overrun_flag, noise_flag, framing_flag, parity_fail_flag} <= USC_STATUS_RESET;
      idle_armed <= 1'b1;
    end else begin
      if (tx_load) begin
        tx_buffer_empty_flag <= 1'b1;
      end else if (clr_tx) begin
        tx_buffer_empty_flag <= 1'b0;
      end
      if (tx_frame_end && tx_kind == K_DATA) begin
        tx_done_flag <= 1'b1;
      end else if (clr_tx) begin
        tx_done_flag <= 1'b0;
      end
      if (rx_load) begin
        rx_ready_flag <= 1'b1;
      end else if (clr_rx) begin
        rx_ready_flag <= 1'b0;
      end
      if (rx_accept && rx_ready_flag) begin
        overrun_flag <= 1'b1;
      end else if (clr_rx) begin
        overrun_flag <= 1'b0;
      end
      if (rx_load && rx_noise) begin
        noise_flag <= 1'b1;
      end else if (clr_rx) begin
        noise_flag <= 1'b0;
      end
      if (rx_load && rx_ferr) begin
        framing_flag <= 1'b1;
      end else if (clr_rx) begin
        framing_flag <= 1'b0;
      end
      if (rx_load && rx_perr) begin
        parity_fail_flag <= 1'b1;
      end else if (clr_rx) begin
        parity_fail_flag <= 1'b0;
      end
      if (rx_idle && !rx_mute && idle_armed) begin
        idle_flag <= 1'b1;
        idle_armed <= 1'b0;
      end else begin
        if (clr_rx) begin
          idle_flag <= 1'b0;
        end
        if (rx_load) begin
          idle_armed <= 1'b1;
        end
      end
    end
  end

  // Control registers
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl1 <= USC_CTRL1_RESET;
    end else if (wr_i && addr_i == USC_ADDR_CTRL1) begin
      ctrl1 <= {1'b0, wdata_i[6:0]};
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl2 <= USC_CTRL2_RESET;
    end else if (wr_i && addr_i == USC_ADDR_CTRL2) begin
      ctrl2 <= wdata_i;
    end else if (wake_addr || idle_wake) begin
      ctrl2[USC_C2_MUTE] <= 1'b0;
    end
  end

  // Transmit data buffer
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_buffer <= 8'h00;
    end else if (wr_data) begin
      tx_buffer <= wdata_i;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        USC_ADDR_STATUS: rdata_o <= {tx_buffer_empty_flag, tx_done_flag, rx_ready_flag,
                                     idle_flag, overrun_flag, noise_flag, framing_flag,
                                     parity_fail_flag};
        USC_ADDR_DATA: rdata_o <= rx_buffer;
        USC_ADDR_CTRL1: rdata_o <= {rx_ninth_bit, ctrl1[6:0]};
        USC_ADDR_CTRL2: rdata_o <= ctrl2;
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  // Transmit word with parity in the top data position
  always_comb begin
    tx_word = {tx_ninth_bit, tx_buffer};
    if (parity_enable) begin
      if (nine_bit) begin
        tx_word[8] = usc_par(tx_word, 1'b1) ^ parity_odd_select;
      end else begin
        tx_word[7] = usc_par(tx_word, 1'b0) ^ parity_odd_select;
      end
    end
  end

  assign tx_bit_end = tx_cnt == 16'(BIT_CLKS - 1);
  assign te_rise = tx_enable && !te_prev;
  assign sbk_fall = !send_break_bit && sbk_prev;
  assign tx_load = (tx_state == TX_READY) && tx_enable && !low_power_stop &&
                   !break_pend && !preamble_pend && !tx_buffer_empty_flag;
  assign tx_frame_end = (tx_state == TX_SHIFT) && tx_bit_end && (tx_bits == 4'h1);

  // Preamble and break requests
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      te_prev <= 1'b0;
      sbk_prev <= 1'b0;
      preamble_pend <= 1'b0;
      break_pend <= 1'b0;
    end else begin
      te_prev <= tx_enable;
      sbk_prev <= send_break_bit;
      if (te_rise && tx_state == TX_SHIFT) begin
        preamble_pend <= 1'b1;
      end else if (tx_state == TX_READY && !break_pend && !low_power_stop) begin
        preamble_pend <= 1'b0;
      end
      if (sbk_fall) begin
        break_pend <= 1'b1;
      end else if (tx_state == TX_READY && !low_power_stop) begin
        break_pend <= 1'b0;
      end
    end
  end

  // Transmit sequencer
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_state <= TX_OFF;
      tx_kind <= K_DATA;
      tx_shift <= 12'hFFF;
      tx_bits <= 4'h0;
      tx_cnt <= 16'h0000;
    end else begin
      tx_cnt <= (tx_bit_end || tx_state == TX_OFF || tx_state == TX_READY) ?
                16'h0000 : tx_cnt + 16'h0001;
      case (tx_state)
        TX_OFF: begin
          if (tx_enable) begin
            tx_state <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (!tx_enable) begin
            tx_state <= TX_OFF;
          end else if (tx_bit_end) begin
            tx_state <= TX_READY;
          end
        end
        TX_READY: begin
          if (!tx_enable) begin
            tx_state <= TX_OFF;
          end else if (!low_power_stop) begin
            if (break_pend) begin
              tx_state <= TX_SHIFT;
              tx_kind <= K_BREAK;
              tx_shift <= nine_bit ? 12'h800 : 12'h400;
              tx_bits <= nine_bit ? 4'hC : 4'hB;
            end else if (preamble_pend) begin
              tx_state <= TX_SHIFT;
              tx_kind <= K_PREAMBLE;
              tx_shift <= 12'hFFF;
              tx_bits <= nine_bit ? USC_FRAME9 : USC_FRAME8;
            end else if (tx_load) begin
              tx_state <= TX_SHIFT;
              tx_kind <= K_DATA;
              tx_shift <= nine_bit ? {2'b11, tx_word, 1'b0} :
                                     {3'b111, tx_word[7:0], 1'b0};
              tx_bits <= nine_bit ? USC_FRAME9 : USC_FRAME8;
            end
          end
        end
        TX_SHIFT: begin
          if (tx_bit_end) begin
            tx_shift <= {1'b1, tx_shift[11:1]};
            tx_bits <= tx_bits - 4'h1;
            if (tx_bits == 4'h1) begin
              tx_state <= tx_enable ? TX_READY : TX_OFF;
            end
          end
        end
        default: tx_state <= TX_OFF;
      endcase
    end
  end

  assign tx_o = (tx_state == TX_SHIFT) ? tx_shift[0] : 1'b1;
  assign tx_oe_o = (tx_enable || rx_enable) &&
                   !(low_power_stop && tx_state != TX_SHIFT);

  // Single combined interrupt request
  assign irq_o = (tx_buffer_empty_flag && tx_empty_irq_enable) ||
                 (tx_done_flag && tx_done_irq_enable) ||
                 (!rx_mute && ((idle_flag && idle_irq_enable) ||
                  (parity_fail_flag && parity_irq_enable) ||
                  (rx_enable && rx_irq_enable && (rx_ready_flag || overrun_flag))));
endmodule
`default_nettype wire

/* File: verification/usc_monitor.sv */
// Port checker for the serial status and control block.
// Assumes the byte register port and BIT_CLKS of at least 4.
`timescale 1ns/1ps
`default_nettype none
module usc_monitor import usc_pkg::*; #(
  parameter int BIT_CLKS = USC_BIT_CLKS
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic rx_i,
  input wire logic tx_o,
  input wire logic tx_oe_o,
  input wire logic irq_o
);
  logic wr_seen;
  logic te_ever;
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Shadows of software writes
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_seen <= 1'b0;
      te_ever <= 1'b0;
      c1_q <= USC_CTRL1_RESET;
      c2_q <= USC_CTRL2_RESET;
    end else if (wr_i) begin
      wr_seen <= 1'b1;
      if (addr_i == USC_ADDR_CTRL1) begin
        c1_q <= wdata_i;
      end
      if (addr_i == USC_ADDR_CTRL2) begin
        c2_q <= wdata_i;
        te_ever <= te_ever | wdata_i[USC_C2_TE];
      end
    end
  end
  status_reset_a: assert property (rd_i && addr_i == USC_ADDR_STATUS && !wr_seen
    |=> rdata_o == USC_STATUS_RESET) else $error("status not at reset value");
  tx_irq_a: assert property (rd_i && addr_i == USC_ADDR_STATUS
    |=> !((rdata_o[7] && c2_q[7]) || (rdata_o[6] && c2_q[6])) || irq_o)
    else $error("enabled transmit flag without interrupt");
  ctrl1_readback_a: assert property (rd_i && addr_i == USC_ADDR_CTRL1
    |=> rdata_o[6:0] == c1_q[6:0]) else $error("control one readback wrong");
  ctrl2_readback_a: assert property (rd_i && addr_i == USC_ADDR_CTRL2
    |=> {rdata_o[7:2], rdata_o[0]} == {c2_q[7:2], c2_q[0]})
    else $error("control two readback wrong");
  start_bit_a: assert property ($fell(tx_o) |-> !tx_o [*4])
    else $error("start bit too short");
  irq_masked_a: assert property (c2_q[7:4] == 4'h0 && !c1_q[USC_C1_PIE] |-> !irq_o)
    else $error("interrupt with all enables clear");
  tx_quiet_a: assert property (!wr_seen |-> tx_o && !tx_oe_o)
    else $error("transmit pin active before enable");
  te_delay_a: assert property (wr_i && addr_i == USC_ADDR_CTRL2 && wdata_i[USC_C2_TE]
    && !te_ever |=> tx_o [*4]) else $error("transmit started within one bit time");
endmodule
bind usc_top usc_monitor #(.BIT_CLKS(BIT_CLKS)) usc_monitor_inst (.ref_clk_i(ref_clk_i),
  .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .rx_i(rx_i), .tx_o(tx_o), .tx_oe_o(tx_oe_o), .irq_o(irq_o));
`default_nettype wire

/* File: verification/usc_remote.sv */
// Remote serial transceiver on the line, LSB first, one stop bit.
// Assumes the bench sets nine and calls send just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module usc_remote #(
  parameter int BIT_CLKS = 4
) (
  input wire logic ref_clk_i,
  input wire logic line_i,
  output logic line_o
);
  logic [8:0] got;
  int got_cnt;
  logic nine;
  initial begin
    line_o = 1'b1;
    got = 9'h000;
    got_cnt = 0;
    nine = 1'b0;
  end
  // Frame out on the line, high when idle
  task automatic send(input logic [8:0] d, input logic stop_bit);
    line_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge ref_clk_i);
    for (int i = 0; i < 8 + int'(nine); i++) begin
      line_o <= d[i];
      repeat (BIT_CLKS) @(posedge ref_clk_i);
    end
    line_o <= stop_bit;
    repeat (BIT_CLKS) @(posedge ref_clk_i);
    line_o <= 1'b1;
  endtask
  // Frame capture at mid-bit
  always begin
    @(negedge line_i);
    got = 9'h000;
    repeat (BIT_CLKS / 2) @(posedge ref_clk_i);
    for (int i = 0; i < 8 + int'(nine); i++) begin
      repeat (BIT_CLKS) @(posedge ref_clk_i);
      got[i] = line_i;
    end
    repeat (BIT_CLKS) @(posedge ref_clk_i);
    got_cnt++;
  end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the serial status and control block.
// Assumes the remote model on the line and BIT_CLKS at its default of 16.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import usc_pkg::*;
  localparam int BC = 16;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic [7:0] rv;
  logic rx_i;
  logic tx_o;
  logic tx_oe_o;
  logic irq_o;
  int n_errors = 0;
  int samples_checked = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  usc_top #(.BIT_CLKS(BC)) usc_top_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_i(rx_i), .tx_o(tx_o), .tx_oe_o(tx_oe_o), .irq_o(irq_o));
  usc_remote #(.BIT_CLKS(BC)) usc_remote_inst (.ref_clk_i(ref_clk_i), .line_i(tx_o),
    .line_o(rx_i));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_reset();
    rd(USC_ADDR_STATUS, rv);
    chk(rv, USC_STATUS_RESET);
    wr(USC_ADDR_STATUS, 8'h00);
    rd(USC_ADDR_STATUS, rv);
    chk(rv, USC_STATUS_RESET);
    rd(USC_ADDR_CTRL1, rv);
    rd(8'h52, rv);
    chk(rv, 8'h00);
    wr(USC_ADDR_CTRL2, 8'hC0);
    chk(irq_o, 1'b1);
    rd(USC_ADDR_STATUS, rv);
    wr(USC_ADDR_CTRL2, 8'h08);
    chk(irq_o, 1'b0);
  endtask
  task automatic tx_case(input logic [7:0] c1, input logic [7:0] d, input logic [8:0] e);
    int n0;
    n0 = usc_remote_inst.got_cnt;
    usc_remote_inst.nine = c1[USC_C1_M];
    wr(USC_ADDR_CTRL1, c1);
    rd(USC_ADDR_STATUS, rv);
    wr(USC_ADDR_DATA, d);
    for (int i = 0; i < 15 * BC && usc_remote_inst.got_cnt == n0; i++) @(posedge ref_clk_i);
    chk(9'(usc_remote_inst.got_cnt - n0), 9'h001);
    chk(usc_remote_inst.got, e);
    repeat (2 * BC) @(posedge ref_clk_i);
  endtask
  task automatic test_tx();
    tx_case(8'h00, 8'hA5, 9'h0A5);
    tx_case(8'h50, 8'h3C, 9'h13C);
    tx_case(8'h04, 8'h83, 9'h003);
    tx_case(8'h06, 8'h03, 9'h083);
    tx_case(8'h14, 8'hFF, 9'h0FF);
    rd(USC_ADDR_STATUS, rv);
    chk(rv & 8'hC0, 8'hC0);
  endtask
  // Break bit set then cleared sends one all-zero word
  task automatic test_break();
    int n0;
    n0 = usc_remote_inst.got_cnt;
    usc_remote_inst.nine = 1'b0;
    wr(USC_ADDR_CTRL1, 8'h00);
    wr(USC_ADDR_CTRL2, 8'h09);
    wr(USC_ADDR_CTRL2, 8'h08);
    repeat (13 * BC) @(posedge ref_clk_i);
    chk(9'(usc_remote_inst.got_cnt - n0), 9'h001);
    chk(usc_remote_inst.got, 9'h000);
  endtask
  // Send one word, then look at the flags and the buffer
  task automatic rx_word(input logic [8:0] d, input logic sb, input logic [7:0] st,
    input logic [7:0] dat, input logic irq);
    usc_remote_inst.send(d, sb);
    repeat (25 * BC) @(posedge ref_clk_i);
    chk(irq_o, irq);
    rd(USC_ADDR_STATUS, rv);
    chk(rv & 8'h3F, st);
    if (st != 8'h00) begin
      rd(USC_ADDR_DATA, rv);
      chk(rv, dat);
      rd(USC_ADDR_STATUS, rv);
      chk(rv & 8'h3F, 8'h00);
    end
  endtask
  task automatic test_rx();
    usc_remote_inst.nine = 1'b0;
    wr(USC_ADDR_CTRL1, 8'h00);
    wr(USC_ADDR_CTRL2, 8'h2C);
    rx_word(9'h05A, 1'b1, 8'h30, 8'h5A, 1'b1);
    usc_remote_inst.send(9'h011, 1'b1);
    rx_word(9'h022, 1'b1, 8'h38, 8'h11, 1'b1);
    rx_word(9'h033, 1'b0, 8'h32, 8'h33, 1'b1);
    wr(USC_ADDR_CTRL1, 8'h05);
    rx_word(9'h001, 1'b1, 8'h31, 8'h01, 1'b1);
  endtask
  task automatic test_mute();
    wr(USC_ADDR_CTRL1, 8'h08);
    wr(USC_ADDR_CTRL2, 8'h2E);
    rx_word(9'h005, 1'b1, 8'h00, 8'h00, 1'b0);
    rx_word(9'h085, 1'b1, 8'h30, 8'h85, 1'b1);
    rd(USC_ADDR_CTRL2, rv);
    chk(rv, 8'h2C);
    wr(USC_ADDR_CTRL1, 8'h00);
    wr(USC_ADDR_CTRL2, 8'h2E);
    rx_word(9'h005, 1'b1, 8'h00, 8'h00, 1'b0);
    rd(USC_ADDR_CTRL2, rv);
    chk(rv, 8'h2C);
  endtask
  task automatic final_report();
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    test_reset();
    test_tx();
    test_break();
    test_rx();
    test_mute();
    final_report();
  end
endmodule
`default_nettype wire
